// ===== logic/otg_event_cfg.svh
// constants for the otg event flag register: offsets, fields, resets, timing
// Notes on behaviour
// - each event flag stays set until software writes a one to it
// - the on-the-go timer time-out sets the flag in bit 10
// - se0 held for more than 2 ms sets the flag in bit 9
// - a recognised session request from the far device sets bit 8
// - control bit 9 chooses vbus pulsing or data-line pulsing detection
// - a j to k change while suspended sets the resume flag, bit 7
// - entering suspend, bus idle over 3 ms, sets the flag in bit 6
// - bits 5 to 0 set whenever the matching status bit changes
`ifndef OTG_EVENT_CFG_SVH
`define OTG_EVENT_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define EVT_FLAGS_OFS 12'h000
`define CONTROL_OFS 12'h004
`define STATUS_OFS 12'h008

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TIMER_EXPIRED_BIT 10
`define LONG_SE0_BIT 9
`define SESSION_REQ_BIT 8
`define RESUME_BIT 7
`define SUSPEND_BIT 6
`define METHOD_SELECT_BIT 9
`define STATUS_SE0_BIT 9
`define EVT_USED_MASK 16'h07ff

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EVT_FLAGS_RESET 16'h0000
`define METHOD_SELECT_RESET 1'b0
`define STATUS_RESET 6'h05

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ 25
`define LONG_SE0_US 2000
`define SUSPEND_IDLE_US 3000
`define LONG_SE0_CYCLES (`LONG_SE0_US * `CLK_MHZ)
`define SUSPEND_IDLE_CYCLES (`SUSPEND_IDLE_US * `CLK_MHZ)
`define TIMER_W 20

`endif

// ===== logic/otg_event_pkg.sv
// types shared by the otg event flag logic
package otg_event_pkg;

    // ----------------------------------------------------------------
    // bus line state as seen from the transceiver
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LINE_SE0 = 2'b00,
        LINE_J = 2'b01,
        LINE_K = 2'b10,
        LINE_SE1 = 2'b11
    } line_state_type;

    // ----------------------------------------------------------------
    // status levels whose changes raise flags 5..0
    // ----------------------------------------------------------------
    typedef struct packed {
        logic remote_pullup;
        logic b_session_valid;
        logic a_session_valid;
        logic b_session_end;
        logic a_vbus_valid;
        logic id_level;
    } otg_status_type;

    // ----------------------------------------------------------------
    // event flag register layout
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [4:0] reserved;
        logic timer_expired_flag;
        logic long_se0_flag;
        logic session_request_seen_flag;
        logic resume_seen_flag;
        logic suspend_entered_flag;
        logic remote_pullup_change_flag;
        logic b_session_valid_change_flag;
        logic a_session_valid_change_flag;
        logic b_session_end_change_flag;
        logic a_vbus_valid_change_flag;
        logic id_level_change_flag;
    } otg_event_flags_type;

endpackage

// ===== logic/duration_timer.sv
// counts how long a condition has held and flags it once past a limit
`timescale 1ns/1ns
module duration_timer #(
    parameter int unsigned LIMIT = 50000,
    parameter int unsigned W = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic active,
    output logic expired
);

    localparam logic [W-1:0] TOP = W'(LIMIT + 1);

    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    logic expired_q;
    logic expired_d;

    // saturate one past the limit so a long condition never wraps back to zero
    always_comb begin
        if (!active) begin
            count_d = '0;
        end else if (count_q == TOP) begin
            count_d = count_q;
        end else begin
            count_d = count_q + W'(1);
        end
        expired_d = (count_d == TOP);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
            expired_q <= 1'b0;
        end else begin
            count_q <= count_d;
            expired_q <= expired_d;
        end
    end

    assign expired = expired_q;

endmodule

// ===== logic/otg_event_flag_register.sv
// otg event flag register with apb slave, line-state detectors and status change flags
`timescale 1ns/1ns
`include "otg_event_cfg.svh"
module otg_event_flag_register
    import otg_event_pkg::*;
#(
    parameter int unsigned LONG_SE0_CYCLES = `LONG_SE0_CYCLES,
    parameter int unsigned SUSPEND_IDLE_CYCLES = `SUSPEND_IDLE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] line_state,
    input wire otg_status_type status_in,
    input wire logic timer_timeout,
    output logic [15:0] otg_event_flags,
    output logic request_method_select,
    output logic suspended
);

    // ----------------------------------------------------------------
    // apb handshake
    // ----------------------------------------------------------------
    // one wait state: pready comes from a flop, so it can only rise the
    // cycle after penable is first seen
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic access_done;
    logic hit_flags;
    logic hit_control;
    logic hit_status;
    logic hit_any;

    // exact word decode: anything else on the bus answers with an error
    always_comb begin
        hit_flags = 1'b0;
        hit_control = 1'b0;
        hit_status = 1'b0;
        case (paddr)
            `EVT_FLAGS_OFS: begin
                hit_flags = 1'b1;
            end
            `CONTROL_OFS: begin
                hit_control = 1'b1;
            end
            `STATUS_OFS: begin
                hit_status = 1'b1;
            end
            default: begin
                hit_flags = 1'b0;
            end
        endcase
        hit_any = hit_flags | hit_control | hit_status;
    end
    // writes land only at the edge where the master sees pready high
    assign access_done = psel & penable & pready_q;

    // ----------------------------------------------------------------
    // line state tracking
    // ----------------------------------------------------------------
    line_state_type line_q;
    line_state_type line_d;
    line_state_type line_now;
    logic se0_long;
    logic se0_long_q;
    logic idle_long;
    logic idle_long_q;
    logic line_is_se0;
    logic line_is_j;

    assign line_now = line_state_type'(line_state);
    assign line_is_se0 = (line_now == LINE_SE0);
    assign line_is_j = (line_now == LINE_J);

    always_comb begin
        line_d = line_now;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_q <= LINE_J;
            se0_long_q <= 1'b0;
            idle_long_q <= 1'b0;
        end else begin
            line_q <= line_d;
            se0_long_q <= se0_long;
            idle_long_q <= idle_long;
        end
    end

    duration_timer #(
        .LIMIT(LONG_SE0_CYCLES),
        .W(`TIMER_W)
    ) u_se0_timer (
        .pclk(pclk),
        .presetn(presetn),
        .active(line_is_se0),
        .expired(se0_long)
    );

    // idle on a full-speed bus is the j state
    duration_timer #(
        .LIMIT(SUSPEND_IDLE_CYCLES),
        .W(`TIMER_W)
    ) u_idle_timer (
        .pclk(pclk),
        .presetn(presetn),
        .active(line_is_j),
        .expired(idle_long)
    );

    // ----------------------------------------------------------------
    // status change tracking
    // ----------------------------------------------------------------
    otg_status_type status_q;
    otg_status_type status_d;
    logic [5:0] status_change;

    always_comb begin
        status_d = status_in;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= otg_status_type'(`STATUS_RESET);
        end else begin
            status_q <= status_d;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_change
            assign status_change[gi] = status_in[gi] ^ status_q[gi];
        end
    endgenerate

    // ----------------------------------------------------------------
    // event sources
    // ----------------------------------------------------------------
    logic method_q;
    logic method_d;
    logic vbus_pulse_seen;
    logic line_pulse_seen;
    logic session_request;
    logic resume_event;
    logic suspend_event;
    logic long_se0_event;
    logic [15:0] set_vec;

    // vbus pulsing shows as a session-valid rise; data-line pulsing as the
    // far device pulling the bus from se0 to j
    assign vbus_pulse_seen = status_in.a_session_valid & ~status_q.a_session_valid;
    assign line_pulse_seen = (line_q == LINE_SE0) & line_is_j;
    assign session_request = method_q ? vbus_pulse_seen : line_pulse_seen;
    // idle_long still reads high in the cycle the bus first shows k
    assign resume_event = idle_long & (line_q == LINE_J) & (line_now == LINE_K);
    assign suspend_event = idle_long & ~idle_long_q;
    assign long_se0_event = se0_long & ~se0_long_q;

    always_comb begin
        set_vec = 16'h0000;
        set_vec[`TIMER_EXPIRED_BIT] = timer_timeout;
        set_vec[`LONG_SE0_BIT] = long_se0_event;
        set_vec[`SESSION_REQ_BIT] = session_request;
        set_vec[`RESUME_BIT] = resume_event;
        set_vec[`SUSPEND_BIT] = suspend_event;
        set_vec[5:0] = status_change;
    end

    // ----------------------------------------------------------------
    // event flag register
    // ----------------------------------------------------------------
    logic [15:0] flags_q;
    logic [15:0] flags_d;
    logic [15:0] clear_vec;
    logic [15:0] lane_mask;

    assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    always_comb begin
        clear_vec = 16'h0000;
        if (access_done && pwrite && hit_flags) begin
            clear_vec = pwdata[15:0] & lane_mask;
        end
        // set beats clear, reserved bits never hold a one
        flags_d = ((flags_q & ~clear_vec) | set_vec) & `EVT_USED_MASK;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= `EVT_FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_comb begin
        method_d = method_q;
        if (access_done && pwrite && hit_control && pstrb[1]) begin
            method_d = pwdata[`METHOD_SELECT_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            method_q <= `METHOD_SELECT_RESET;
        end else begin
            method_q <= method_d;
        end
    end

    // ----------------------------------------------------------------
    // read data selection
    // ----------------------------------------------------------------
    // each register's word is built on its own so unused bits are plainly zero
    logic [31:0] flags_word;
    logic [31:0] control_word;
    logic [31:0] status_word;
    logic [31:0] read_word;

    always_comb begin
        flags_word = 32'h0000_0000;
        flags_word[15:0] = flags_q;
    end

    always_comb begin
        control_word = 32'h0000_0000;
        control_word[`METHOD_SELECT_BIT] = method_q;
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`STATUS_SE0_BIT] = se0_long;
        status_word[5:0] = status_q;
    end

    always_comb begin
        read_word = 32'h0000_0000;
        if (hit_flags) begin
            read_word = flags_word;
        end else if (hit_control) begin
            read_word = control_word;
        end else if (hit_status) begin
            read_word = status_word;
        end
    end

    // ----------------------------------------------------------------
    // handshake registers
    // ----------------------------------------------------------------
    logic first_access;

    // data and error are captured in the first access cycle only; the word
    // then stands still in prdata_q while pready is high
    assign first_access = psel & penable & ~pready_q;

    always_comb begin
        pready_d = first_access;
        pslverr_d = 1'b0;
        prdata_d = 32'h0000_0000;
        if (first_access) begin
            pslverr_d = ~hit_any;
            if (!pwrite) begin
                prdata_d = read_word;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign otg_event_flags = flags_q;
    assign request_method_select = method_q;
    assign suspended = idle_long;

endmodule

// ===== tb/otg_event_flag_register_monitor.sv
// checker for the otg event flag register, bound to its ports
`timescale 1ns/1ns
module otg_event_flag_register_monitor
    import otg_event_pkg::*;
#(
    parameter int unsigned LONG_SE0_CYCLES = 50000,
    parameter int unsigned SUSPEND_IDLE_CYCLES = 75000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] line_state,
    input wire otg_status_type status_in,
    input wire logic timer_timeout,
    input wire logic [15:0] otg_event_flags,
    input wire logic request_method_select,
    input wire logic suspended
);
    logic [19:0] se0_q, se0_d, idle_q, idle_d;
    logic [5:0] hist_q, hist_d, chg;
    logic wr_q, wr_d;
    // run lengths stay well below wrap for any run this bench makes
    always_comb begin
        se0_d = (line_state == 2'b00) ? se0_q + 20'h00001 : 20'h00000;
        idle_d = (line_state == 2'b01) ? idle_q + 20'h00001 : 20'h00000;
        hist_d = status_in;
        chg = status_in ^ hist_q;
        wr_d = psel && penable && pready && pwrite && paddr == 12'h000;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            se0_q <= 20'h00000;
            idle_q <= 20'h00000;
            hist_q <= 6'h05;
            wr_q <= 1'b0;
        end else begin
            se0_q <= se0_d;
            idle_q <= idle_d;
            hist_q <= hist_d;
            wr_q <= wr_d;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    sequence s_j_to_k; suspended && line_state == 2'b01 ##1 line_state == 2'b10; endsequence
    property p_sticky; (|($past(otg_event_flags) & ~otg_event_flags)) |-> wr_q; endproperty
    property p_timer; timer_timeout |=> otg_event_flags[10]; endproperty
    property p_long_se0; se0_q == LONG_SE0_CYCLES + 2 |-> ##[0:2] otg_event_flags[9]; endproperty
    property p_srp_line;
        !request_method_select && $past(line_state) == 2'b00 && line_state == 2'b01
            |=> otg_event_flags[8];
    endproperty
    property p_srp_vbus;
        request_method_select && $rose(status_in.a_session_valid) |=> otg_event_flags[8];
    endproperty
    property p_resume; s_j_to_k |-> ##[1:2] otg_event_flags[7]; endproperty
    property p_suspend;
        idle_q == SUSPEND_IDLE_CYCLES + 2 |-> ##[0:2] (suspended && otg_event_flags[6]);
    endproperty
    property p_status; (|chg) |=> (otg_event_flags[5:0] & $past(chg)) == $past(chg); endproperty
    property p_reserved; otg_event_flags[15:11] == 5'h00; endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without a clearing write");
    a_timer: assert property (p_timer)
        else $error("timer time-out not flagged");
    a_long_se0: assert property (p_long_se0)
        else $error("long se0 not flagged");
    a_srp_line: assert property (p_srp_line)
        else $error("data-line session request not flagged");
    a_srp_vbus: assert property (p_srp_vbus)
        else $error("vbus session request not flagged");
    a_resume: assert property (p_resume)
        else $error("resume not flagged");
    a_suspend: assert property (p_suspend)
        else $error("suspend entry not flagged");
    a_status: assert property (p_status)
        else $error("status change not flagged");
    a_reserved: assert property (p_reserved)
        else $error("reserved flag bits not zero");
endmodule

bind otg_event_flag_register otg_event_flag_register_monitor #(
    .LONG_SE0_CYCLES(LONG_SE0_CYCLES), .SUSPEND_IDLE_CYCLES(SUSPEND_IDLE_CYCLES)
) otg_event_flag_register_monitor_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_state(line_state), .status_in(status_in),
    .timer_timeout(timer_timeout), .otg_event_flags(otg_event_flags),
    .request_method_select(request_method_select), .suspended(suspended)
);

// ===== tb/far_device.sv
// model of the remote otg device: bus line state and session levels
`timescale 1ns/1ns
module far_device
    import otg_event_pkg::*;
(
    input wire logic pclk,
    output logic [1:0] line_state,
    output otg_status_type status_in
);
    // idle bus is j through the pull-up; levels start at the status reset history
    initial begin
        line_state = 2'b01;
        status_in = 6'h05;
    end
    // se0 followed by j is data-line pulsing; call just after a rising edge
    task automatic hold(input logic [1:0] state, input int cycles);
        line_state <= state;
        repeat (cycles) @(posedge pclk);
    endtask
    // a rise of a_session_valid is vbus pulsing
    task automatic flip(input int bit_pos);
        status_in[bit_pos] <= ~status_in[bit_pos];
        @(posedge pclk);
    endtask
endmodule

// ===== tb/otg_event_flag_register_test.sv
// self-checking bench for the otg event flag register
`timescale 1ns/1ns
module otg_event_flag_register_test;
    import otg_event_pkg::*;
    localparam int unsigned SE0_LIMIT = 20;
    localparam int unsigned IDLE_LIMIT = 30;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic timer_timeout = 1'b0;
    logic [31:0] prdata, rd_data;
    logic pready, pslverr, request_method_select, suspended, rd_err;
    logic [1:0] line_state;
    otg_status_type status_in;
    logic [15:0] otg_event_flags;
    int fail_count = 0;
    int samples_checked = 0;
    always #20 pclk = ~pclk;
    far_device far_device_inst (.pclk(pclk), .line_state(line_state), .status_in(status_in));
    otg_event_flag_register #(.LONG_SE0_CYCLES(SE0_LIMIT), .SUSPEND_IDLE_CYCLES(IDLE_LIMIT))
    otg_event_flag_register_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_state(line_state), .status_in(status_in),
        .timer_timeout(timer_timeout), .otg_event_flags(otg_event_flags),
        .request_method_select(request_method_select), .suspended(suspended)
    );
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d of %0d checks", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // starts one edge in, so a release and the next setup never share a time step
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fail_count++;
            end_of_test();
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic read_flags(input logic [31:0] mask, input logic [31:0] want);
        apb(1'b0, 12'h000, 32'h0);
        check("flags", rd_data & mask, want);
        check("flag port", {16'h0000, otg_event_flags} & mask, want);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic check_status_changes();
        for (int i = 0; i < 6; i++) begin
            far_device_inst.flip(i);
            read_flags(32'h3f, 32'h1 << i);
            apb(1'b1, 12'h000, 32'h0);
            read_flags(32'h3f, 32'h1 << i);
            apb(1'b1, 12'h000, 32'h1 << i);
            read_flags(32'h3f, 32'h0);
        end
    endtask
    task automatic check_timer();
        timer_timeout <= 1'b1;
        @(posedge pclk);
        timer_timeout <= 1'b0;
        read_flags(32'hfc00, 32'h400);
        // lane 1 strobe off: the clear of bit 10 must not land
        pstrb <= 4'h1;
        apb(1'b1, 12'h000, 32'h400);
        pstrb <= 4'hf;
        read_flags(32'h400, 32'h400);
        apb(1'b1, 12'h000, 32'hffffffff);
        read_flags(32'hfc00, 32'h0);
        timer_timeout <= 1'b1;
        apb(1'b1, 12'h000, 32'h400);
        timer_timeout <= 1'b0;
        read_flags(32'h400, 32'h400);
    endtask
    task automatic check_long_se0();
        apb(1'b1, 12'h000, 32'h300);
        far_device_inst.hold(2'b00, SE0_LIMIT);
        far_device_inst.hold(2'b01, 1);
        read_flags(32'h300, 32'h100);
        apb(1'b1, 12'h000, 32'h300);
        far_device_inst.hold(2'b00, SE0_LIMIT + 3);
        apb(1'b0, 12'h008, 32'h0);
        check("status", rd_data, 32'h23a);
        far_device_inst.hold(2'b01, 1);
        read_flags(32'h300, 32'h300);
    endtask
    task automatic check_vbus_method();
        apb(1'b1, 12'h004, 32'h200);
        far_device_inst.flip(3);
        apb(1'b1, 12'h000, 32'h10f);
        far_device_inst.hold(2'b00, 3);
        far_device_inst.hold(2'b01, 1);
        check("method", {31'h0, request_method_select}, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        check("control", rd_data, 32'h200);
        read_flags(32'h100, 32'h0);
        far_device_inst.flip(3);
        read_flags(32'h108, 32'h108);
        apb(1'b1, 12'h004, 32'h0);
    endtask
    task automatic check_suspend_resume();
        far_device_inst.hold(2'b10, 1);
        far_device_inst.hold(2'b01, IDLE_LIMIT + 3);
        check("suspended", {31'h0, suspended}, 32'h1);
        read_flags(32'h40, 32'h40);
        apb(1'b1, 12'h000, 32'hc0);
        far_device_inst.hold(2'b10, 2);
        check("suspended", {31'h0, suspended}, 32'h0);
        read_flags(32'hc0, 32'h80);
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        read_flags(32'hffffffff, 32'h0);
        check("method", {31'h0, request_method_select}, 32'h0);
        check_status_changes();
        check_timer();
        check_long_se0();
        check_vbus_method();
        check_suspend_resume();
        apb(1'b0, 12'hffc, 32'h0);
        check("unmapped error", {31'h0, rd_err}, 32'h1);
        check("unmapped data", rd_data, 32'h0);
        end_of_test();
    end
endmodule
